// [core/dmx_exec.sv]
// Purpose: Executes or, move-file, load-pointer and file-to-file moves.
// Assumes: Software writes instruction words into the instruction register.
// Notes: Two-word ops wait for their second word; memory is preloaded
//   through the memory address and data registers.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/10ps
module dmx_exec #(
    parameter int AW = dmx_pkg::ADDR_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic [7:0] w_r, w_nxt;
    logic [3:0] bank_r, bank_nxt;
    logic ext_r, ext_nxt;
    logic n_r, n_nxt, z_r, z_nxt;
    logic bad_dest_r, bad_dest_nxt, bad_op_r, bad_op_nxt;
    logic [11:0] ptr_r [0:2];
    logic [11:0] ptr_nxt [0:2];
    logic [11:0] maddr_r, maddr_nxt;
    logic [15:0] first_r, first_nxt;
    logic [15:0] iw_r, iw_nxt;
    dmx_pkg::dmx_state_e st_r, st_nxt;
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt;
    logic we;
    logic [11:0] waddr, raddr;
    logic [7:0] wdata, rdata;
    logic [11:0] fadr;
    logic [7:0] res;
    logic acc;
    logic [1:0] pi;
    logic [15:0] opw;

    dmx_ram #(.AW(AW), .DW(dmx_pkg::DATA_W)) u_ram (
        .clk(pclk),
        .we(we),
        .waddr(waddr),
        .wdata(wdata),
        .raddr(raddr),
        .rdata(rdata)
    );

    wire setup = psel && !penable;
    wire wr_acc = psel && penable && pwrite && pready;
    wire busy = (st_r != dmx_pkg::DMX_IDLE);

    // Operand address of a single-word op from f, a and bank.
    // The word being written is decoded at once: the memory read is
    // registered, so the operand must be requested before execution.
    always_comb begin
        opw = iw_r;
        if (wr_acc && paddr == dmx_pkg::REG_INSTR &&
            st_r == dmx_pkg::DMX_IDLE) begin
            opw = pwdata[15:0];
        end
        acc = !opw[8];
        if (acc && ext_r && opw[7:0] <= dmx_pkg::IDX_LIMIT) begin
            fadr = ptr_r[2] + {4'h0, opw[7:0]};
        end else if (acc) begin
            // Access bank: f below 0x60 from bank 0, f from 0x60 up from SFRs
            fadr = (opw[7:0] < dmx_pkg::ACCESS_SPLIT) ?
                {4'h0, opw[7:0]} :
                {dmx_pkg::SFR_BANK, opw[7:0]};
        end else begin
            fadr = {bank_r, opw[7:0]};
        end
    end

    always_comb begin
        st_nxt = st_r;
        w_nxt = w_r;
        bank_nxt = bank_r;
        ext_nxt = ext_r;
        n_nxt = n_r;
        z_nxt = z_r;
        bad_dest_nxt = bad_dest_r;
        bad_op_nxt = bad_op_r;
        maddr_nxt = maddr_r;
        first_nxt = first_r;
        iw_nxt = iw_r;
        for (int i = 0; i < 3; i++) begin
            ptr_nxt[i] = ptr_r[i];
        end
        we = 1'b0;
        waddr = maddr_r;
        wdata = pwdata[7:0];
        raddr = fadr;
        res = rdata;
        pi = first_r[5:4];
        if (wr_acc) begin
            case (paddr)
                dmx_pkg::REG_WREG: w_nxt = pwdata[7:0];
                dmx_pkg::REG_BANK: bank_nxt = pwdata[3:0];
                dmx_pkg::REG_CTRL: ext_nxt = pwdata[dmx_pkg::CT_EXT];
                dmx_pkg::REG_MADDR: maddr_nxt = pwdata[11:0];
                dmx_pkg::REG_MDATA: begin
                    we = !busy;
                    maddr_nxt = maddr_r + 12'h001;
                end
                dmx_pkg::REG_INSTR: begin
                    iw_nxt = pwdata[15:0];
                    if (st_r == dmx_pkg::DMX_IDLE) begin
                        st_nxt = dmx_pkg::DMX_EXEC;
                    end else if (st_r == dmx_pkg::DMX_WAIT2) begin
                        st_nxt = dmx_pkg::DMX_FINISH;
                    end
                end
                default: ;
            endcase
        end
        case (st_r)
            dmx_pkg::DMX_IDLE: ;
            // Read of the operand was issued the cycle before
            dmx_pkg::DMX_EXEC: begin
                st_nxt = dmx_pkg::DMX_IDLE;
                bad_op_nxt = 1'b0;
                bad_dest_nxt = 1'b0;
                first_nxt = iw_r;
                if (iw_r[15:10] == dmx_pkg::OPC_OR) begin
                    res = w_r | rdata;
                    n_nxt = res[7];
                    z_nxt = (res == 8'h00);
                end else if (iw_r[15:10] == dmx_pkg::OPC_MOVE_FILE) begin
                    n_nxt = rdata[7];
                    z_nxt = (rdata == 8'h00);
                end
                if (iw_r[15:10] == dmx_pkg::OPC_OR ||
                    iw_r[15:10] == dmx_pkg::OPC_MOVE_FILE) begin
                    if (!iw_r[9]) begin
                        w_nxt = res;
                    end else if (fadr == dmx_pkg::ADR_WREG) begin
                        w_nxt = res;
                    end else begin
                        we = 1'b1;
                        waddr = fadr;
                        wdata = res;
                    end
                end else if (iw_r[15:8] == dmx_pkg::OPC_LDPTR &&
                    iw_r[5:4] != 2'b11) begin
                    ptr_nxt[iw_r[5:4]] = {iw_r[3:0], ptr_r[iw_r[5:4]][7:0]};
                    st_nxt = dmx_pkg::DMX_WAIT2;
                end else if (iw_r[15:12] == dmx_pkg::OPC_FILE_TO_FILE) begin
                    st_nxt = dmx_pkg::DMX_WAIT2;
                end else begin
                    bad_op_nxt = 1'b1;
                end
            end
            dmx_pkg::DMX_WAIT2: ;
            dmx_pkg::DMX_FINISH: begin
                st_nxt = dmx_pkg::DMX_IDLE;
                if (iw_r[15:12] != dmx_pkg::OPC_SECOND) begin
                    bad_op_nxt = 1'b1;
                end else if (first_r[15:12] == dmx_pkg::OPC_FILE_TO_FILE)
                    begin
                    if (iw_r[11:0] == dmx_pkg::ADR_PC_LOW ||
                        iw_r[11:0] == dmx_pkg::ADR_STACK_LOW ||
                        iw_r[11:0] == dmx_pkg::ADR_STACK_HIGH ||
                        iw_r[11:0] == dmx_pkg::ADR_STACK_UPPER) begin
                        bad_dest_nxt = 1'b1;
                    end else if (iw_r[11:0] == dmx_pkg::ADR_WREG) begin
                        w_nxt = (first_r[11:0] == dmx_pkg::ADR_WREG) ?
                            w_r : rdata;
                    end else begin
                        we = 1'b1;
                        waddr = iw_r[11:0];
                        wdata = (first_r[11:0] == dmx_pkg::ADR_WREG) ?
                            w_r : rdata;
                    end
                end else begin
                    ptr_nxt[pi] = {ptr_r[pi][11:8], iw_r[7:0]};
                end
            end
            default: st_nxt = dmx_pkg::DMX_IDLE;
        endcase
        // Keep the source byte on the read port for the second word
        if (st_r == dmx_pkg::DMX_WAIT2 || st_r == dmx_pkg::DMX_FINISH) begin
            raddr = first_r[11:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= dmx_pkg::DMX_IDLE;
            w_r <= 8'h00;
            bank_r <= 4'h0;
            ext_r <= 1'b0;
            n_r <= 1'b0;
            z_r <= 1'b0;
            bad_dest_r <= 1'b0;
            bad_op_r <= 1'b0;
            maddr_r <= 12'h000;
            first_r <= 16'h0000;
            iw_r <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            w_r <= w_nxt;
            bank_r <= bank_nxt;
            ext_r <= ext_nxt;
            n_r <= n_nxt;
            z_r <= z_nxt;
            bad_dest_r <= bad_dest_nxt;
            bad_op_r <= bad_op_nxt;
            maddr_r <= maddr_nxt;
            first_r <= first_nxt;
            iw_r <= iw_nxt;
        end
    end

    // One register per pointer; the next values come from the main decode
    for (genvar g = 0; g < 3; g++) begin : g_ptr
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ptr_r[g] <= 12'h000;
            end else begin
                ptr_r[g] <= ptr_nxt[g];
            end
        end
    end

    // Answer group: decoded in setup so that data, ready and error all
    // stand in the access cycle. Limitation: a register that changes
    // during the setup cycle is read with its old value.
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        if (setup) begin
            pready_nxt = 1'b1;
            case (paddr)
                dmx_pkg::REG_INSTR, dmx_pkg::REG_WREG, dmx_pkg::REG_BANK,
                dmx_pkg::REG_CTRL, dmx_pkg::REG_PTR0, dmx_pkg::REG_PTR1,
                dmx_pkg::REG_PTR2, dmx_pkg::REG_MADDR, dmx_pkg::REG_MDATA:
                    pslverr_nxt = 1'b0;
                dmx_pkg::REG_STATUS: pslverr_nxt = pwrite;
                default: pslverr_nxt = 1'b1;
            endcase
        end
        if (setup && !pwrite) begin
            case (paddr)
                dmx_pkg::REG_WREG: prdata_nxt = {24'h00_0000, w_r};
                dmx_pkg::REG_BANK: prdata_nxt = {28'h000_0000, bank_r};
                dmx_pkg::REG_CTRL: prdata_nxt = {31'h0000_0000, ext_r};
                dmx_pkg::REG_STATUS: prdata_nxt = {27'h000_0000, bad_op_r,
                    bad_dest_r, z_r, n_r, busy};
                dmx_pkg::REG_PTR0: prdata_nxt = {20'h0_0000, ptr_r[0]};
                dmx_pkg::REG_PTR1: prdata_nxt = {20'h0_0000, ptr_r[1]};
                dmx_pkg::REG_PTR2: prdata_nxt = {20'h0_0000, ptr_r[2]};
                dmx_pkg::REG_MADDR: prdata_nxt = {20'h0_0000, maddr_r};
                dmx_pkg::REG_INSTR: prdata_nxt = {16'h0000, iw_r};
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end
endmodule

// [core/dmx_pkg.sv]
// Purpose: Constants for the data-move instruction executor.
// Assumes: 12-bit data space, 8-bit data, 16-bit instruction words.
// Notes: Register map is reached over APB; see the executor module.
// How it works
// - Extended mode, a=0, f<=95: indexed offset
// - Move-file d=0 to W, d=1 back
// - Move-file 8-bit operand spans one bank
// - a=0 access bank, a=1 bank select
// - File-to-file copies source, source unchanged
// - File-to-file uses full 12-bit addresses
// - W may be source or destination
// - Load-pointer: upper four high, lower eight low
// - Refuse PC low and stack-top destinations
package dmx_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    // APB byte addresses
    localparam logic [7:0] REG_INSTR = 8'h00;
    localparam logic [7:0] REG_WREG = 8'h04;
    localparam logic [7:0] REG_BANK = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_PTR0 = 8'h14;
    localparam logic [7:0] REG_PTR1 = 8'h18;
    localparam logic [7:0] REG_PTR2 = 8'h1C;
    localparam logic [7:0] REG_MADDR = 8'h20;
    localparam logic [7:0] REG_MDATA = 8'h24;
    // Opcode fields, top bits of the first word; OPC_SECOND tops the second word
    localparam logic [5:0] OPC_OR = 6'h04;
    localparam logic [5:0] OPC_MOVE_FILE = 6'h14;
    localparam logic [7:0] OPC_LDPTR = 8'hEE;
    localparam logic [3:0] OPC_FILE_TO_FILE = 4'hC;
    localparam logic [3:0] OPC_SECOND = 4'hF;
    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] SFR_BANK = 4'hF;
    // Special addresses
    localparam logic [11:0] ADR_WREG = 12'hFE8;
    localparam logic [11:0] ADR_PC_LOW = 12'hFF9;
    localparam logic [11:0] ADR_STACK_LOW = 12'hFFD;
    localparam logic [11:0] ADR_STACK_HIGH = 12'hFFE;
    localparam logic [11:0] ADR_STACK_UPPER = 12'hFFF;
    // Status and control bits
    localparam int ST_BUSY = 0;
    localparam int ST_N = 1;
    localparam int ST_Z = 2;
    localparam int ST_BADDEST = 3;
    localparam int ST_BADOP = 4;
    localparam int CT_EXT = 0;
    typedef enum logic [1:0] {
        DMX_IDLE, DMX_EXEC, DMX_WAIT2, DMX_FINISH
    } dmx_state_e;
endpackage

// [core/dmx_ram.sv]
// Purpose: Data memory of the executor, one write and one read port.
// Assumes: Read data registered, one cycle latency.
// Notes: Depth follows the address width.
`timescale 1ns/10ps
module dmx_ram #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// [tb/data_move_instruction_exec_test.sv]
// Purpose: Self-checking bench for the data-move executor.
// Assumes: Memory is seen only through move-file and or results in W and in the flags.
// Notes: Every access leaves one idle cycle; simpler than back-to-back.
`timescale 1ns/10ps
module data_move_instruction_exec_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] r;
    logic e;
    int fails = 0;
    int num_checks = 0;
    dmx_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial forever #25 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h", $time, m, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            $display("unexpected at %0t: no pready", $time);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic exec(input logic [15:0] w);
        apb(1'b1, dmx_pkg::REG_INSTR, {16'h0000, w});
        for (int n = 0; n < 10; n++) begin
            apb(1'b0, dmx_pkg::REG_STATUS, 32'h0000_0000);
            if (r[dmx_pkg::ST_BUSY] === 1'b0) break;
        end
    endtask
    task automatic exec2(input logic [15:0] w1, w2);
        apb(1'b1, dmx_pkg::REG_INSTR, {16'h0000, w1});
        apb(1'b0, dmx_pkg::REG_STATUS, 32'h0000_0000);
        chk(r & 32'h0000_0001, 32'h0000_0001, "busy");
        exec(w2);
    endtask
    task automatic mem_wr(input logic [11:0] a, input logic [7:0] v);
        apb(1'b1, dmx_pkg::REG_MADDR, {20'h0_0000, a});
        apb(1'b1, dmx_pkg::REG_MDATA, {24'h00_0000, v});
    endtask
    task automatic mem_rd(input logic [11:0] a);
        apb(1'b1, dmx_pkg::REG_BANK, {28'h000_0000, a[11:8]});
        exec({8'h51, a[7:0]});
        apb(1'b0, dmx_pkg::REG_WREG, 32'h0000_0000);
    endtask
    task automatic t_ptr();
        exec2(16'hEE23, 16'hF0AB);
        apb(1'b0, dmx_pkg::REG_PTR2, 32'h0000_0000);
        chk(r, 32'h0000_03AB, "pointer");
        apb(1'b0, dmx_pkg::REG_STATUS, 32'h0000_0000);
        chk(r & 32'h0000_0006, 32'h0000_0000, "flags");
        $display("test ptr done");
    endtask
    task automatic t_move_file();
        mem_wr(12'h2FF, 8'h80);
        mem_rd(12'h2FF);
        chk(r, 32'h0000_0080, "move to W");
        mem_wr(12'h270, 8'h00);
        exec(16'h5370);
        apb(1'b0, dmx_pkg::REG_WREG, 32'h0000_0000);
        chk(r, 32'h0000_0080, "W kept");
        apb(1'b0, dmx_pkg::REG_STATUS, 32'h0000_0000);
        chk(r & 32'h0000_0006, 32'h0000_0004, "zero flag");
        $display("test move done");
    endtask
    task automatic t_bank();
        logic [11:0] ad[5] = '{12'hF70, 12'h020, 12'h3CB, 12'h40A, 12'hF60};
        logic [7:0] f[5] = '{8'h70, 8'h20, 8'h20, 8'h5F, 8'h60};
        for (int i = 0; i < 5; i++) begin
            if (i == 2) apb(1'b1, dmx_pkg::REG_CTRL, 32'h0000_0001);
            mem_wr(ad[i], 8'h11 * (i + 1));
            exec({8'h50, f[i]});
            apb(1'b0, dmx_pkg::REG_WREG, 32'h0000_0000);
            chk(r, 32'h11 * (i + 1), "bank map");
        end
        apb(1'b1, dmx_pkg::REG_CTRL, 32'h0000_0000);
        $display("test bank done");
    endtask
    task automatic t_ff();
        logic [11:0] bad[4] = '{12'hFF9, 12'hFFD, 12'hFFE, 12'hFFF};
        mem_wr(12'h123, 8'h5A);
        mem_wr(12'hABC, 8'h00);
        exec2(16'hC123, 16'hFABC);
        mem_rd(12'hABC);
        chk(r, 32'h0000_005A, "copy");
        mem_rd(12'h123);
        chk(r, 32'h0000_005A, "source");
        mem_wr(12'h001, 8'hC3);
        exec2(16'hC001, 16'hFFE8);
        apb(1'b0, dmx_pkg::REG_WREG, 32'h0000_0000);
        chk(r, 32'h0000_00C3, "W dest");
        exec2(16'hCFE8, 16'hF456);
        mem_rd(12'h456);
        chk(r, 32'h0000_00C3, "W source");
        foreach (bad[i]) begin
            exec2(16'hC123, {4'hF, bad[i]});
            apb(1'b0, dmx_pkg::REG_STATUS, 32'h0000_0000);
            chk(r & 32'h0000_0008, 32'h0000_0008, "bad dest");
        end
        $display("test ff done");
    endtask
    task automatic t_or();
        apb(1'b1, dmx_pkg::REG_WREG, 32'h0000_0091);
        mem_wr(12'h213, 8'h13);
        apb(1'b1, dmx_pkg::REG_BANK, 32'h0000_0002);
        exec(16'h1113);
        apb(1'b0, dmx_pkg::REG_WREG, 32'h0000_0000);
        chk(r, 32'h0000_0093, "or into W");
        chk({31'h0, e}, 32'h0000_0000, "slave error");
        apb(1'b0, dmx_pkg::REG_STATUS, 32'h0000_0000);
        chk(r & 32'h0000_0006, 32'h0000_0002, "or flags");
        exec(16'h0000);
        apb(1'b0, dmx_pkg::REG_STATUS, 32'h0000_0000);
        chk(r & 32'h0000_0010, 32'h0000_0010, "bad op");
        $display("test or done");
    endtask
    task automatic t_apb();
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({r[30:0], e}, 32'h0000_0001, "unmapped");
        apb(1'b1, dmx_pkg::REG_STATUS, 32'h0000_0006);
        chk({31'h0, e}, 32'h0000_0001, "status ro");
        $display("test apb done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        fails++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_ptr();
        t_move_file();
        t_or();
        t_bank();
        t_ff();
        t_apb();
        complete_run();
    end
endmodule

// [tb/dmx_exec_props.sv]
// Purpose: Port-level checks on the executor's APB answers.
// Assumes: pready stands one cycle, in the cycle after setup.
// Notes: Read widths follow the register sizes.
`timescale 1ns/10ps
module dmx_exec_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence rd_s(a);
        pready && !pwrite && paddr == a;
    endsequence
    ready_after_setup_a: assert property (setup_s |=> pready)
        else $error("no pready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    w_width_a: assert property (rd_s(dmx_pkg::REG_WREG) |->
        prdata[31:8] == 24'h00_0000) else $error("W read too wide");
    bank_width_a: assert property (rd_s(dmx_pkg::REG_BANK) |->
        prdata[31:4] == 28'h000_0000) else $error("bank read too wide");
    ptr_width_a: assert property (rd_s(dmx_pkg::REG_PTR2) |->
        prdata[31:12] == 20'h0_0000) else $error("pointer too wide");
    status_width_a: assert property (rd_s(dmx_pkg::REG_STATUS) |->
        prdata[31:5] == 27'h000_0000) else $error("status too wide");
    status_ro_a: assert property (setup_s ##0
        (pwrite && paddr == dmx_pkg::REG_STATUS) |=> pslverr)
        else $error("status write not refused");
endmodule
bind dmx_exec dmx_exec_props u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
